/* rtl/fpm_pkg.sv */
// constants shared by the maintenance step-control block and its helpers
// assumes one 25 MHz clock and 18-bit memory words
`default_nettype none
package fpm_pkg;
    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 18;
    localparam logic [17:0] NOP_WORD = 18'h39000;     // octal 710000
    localparam logic [17:0] STEP_BASE = 18'h39040;    // octal 710100, n steps added on top
    localparam int MODE_BIT = 6;                      // bit 11 counted from the msb end; 0 read, 1 step
    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] DUMP_LAST = 4'hf;          // sixteen words, index 0..15
    localparam int MAX_SHIFT_STEPS = 35;              // align or normalize shifts per op
    localparam logic [2:0] PH_RESET = 3'h1;           // phase one
    localparam logic [2:0] TS_RESET = 3'h1;           // time state one
    localparam logic [17:0] WORD_RESET = 18'h00000;
    // ------------------------------------------------------------
    // control states
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ARMED = 9'h002,
        ST_CAPTURE = 9'h004,
        ST_DUMMY = 9'h008,
        ST_HALTED = 9'h010,
        ST_CMD_ADDR = 9'h020,
        ST_CMD_NOP = 9'h040,
        ST_READ = 9'h080,
        ST_STEP = 9'h100
    } ctl_state_t;
endpackage : fpm_pkg
`default_nettype wire

/* rtl/phase_gen.sv */
// phase and time-state sequencer of the coprocessor clock
// assumes run_in is low while the clock is stopped; then both counters freeze
`default_nettype none
module phase_gen
    import fpm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic run_in,
    output logic [2:0] phase_out,
    output logic [2:0] tstate_out
);
    logic [2:0] ph_q, ph_d, ts_q, ts_d;

    // rotate one-hot phase each running cycle; time state moves after phase three
    always_comb begin
        ph_d = ph_q;
        ts_d = ts_q;
        if (run_in) begin
            ph_d = {ph_q[1:0], ph_q[2]};
            if (ph_q[2]) begin
                ts_d = {ts_q[1:0], ts_q[2]};
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ph_q <= PH_RESET;
            ts_q <= TS_RESET;
        end else begin
            ph_q <= ph_d;
            ts_q <= ts_d;
        end
    end

    assign phase_out = ph_q;
    assign tstate_out = ts_q;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_phase_frozen: assert property (!run_in |=> $stable(ph_q))
        else $error("phase moved while stopped");
    a_ts_advance: assert property (run_in && ph_q[2]
        |=> ts_q == {$past(ts_q[1:0]), $past(ts_q[2])})
        else $error("time state did not advance after phase three");
endmodule : phase_gen
`default_nettype wire

/* rtl/step_detect.sv */
// decides whether the current phase three is a counted diagnostic step
// assumes the cycle flags are one-hot and valid during phase three
`default_nettype none
module step_detect
    import fpm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic enable_in,
    input wire logic [2:0] phase_in,
    input wire logic [2:0] tstate_in,
    input wire logic [5:0] cycle_in,
    input wire logic shift_in,
    input wire logic store_word_in,
    output logic step_out
);
    logic hit;
    logic step_q, step_d;

    // cycle_in: 0 fetch, 1 operand, 2 align, 3 arith, 4 adjust, 5 write
    always_comb begin
        hit = 1'b0;
        // ts3 steps in fetch and operand, all ts in arith
        if ((cycle_in[0] || cycle_in[1]) && tstate_in[2]) hit = 1'b1;
        if (cycle_in[3]) hit = 1'b1;
        // align counts ts1, ts3 and every align shift in ts2
        if (cycle_in[2]) hit = tstate_in[1] ? shift_in : 1'b1;
        // adjust counts every normalize shift in ts1
        if (cycle_in[4]) hit = tstate_in[0] ? shift_in : 1'b1;
        // store cycle counts each stored word at ts3
        if (cycle_in[5]) hit = tstate_in[2] && store_word_in;
        // only once, at phase three, while stepping
        step_d = enable_in && phase_in[2] && hit;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) step_q <= 1'b0;
        else step_q <= step_d;
    end

    assign step_out = step_q;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_step_phase: assert property (step_q |-> $past(phase_in[2]) && $past(enable_in))
        else $error("step outside phase three");
    a_store_step: assert property (cycle_in[5] && phase_in[2] && tstate_in[2] && enable_in
        && store_word_in |=> step_q) else $error("stored word not counted");
endmodule : step_detect
`default_nettype wire

/* rtl/fp_maintenance_step_control.sv */
// maintenance-mode entry, halting, command capture and step counting
// assumes memory and cpu handshakes are synchronous single-clock inputs
`default_nettype none

module fp_maintenance_step_control
    import fpm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic diag_mode_on_in,
    input wire logic fp_instr_in,
    input wire logic mem_valid_in,
    input wire logic [17:0] mem_word_in,
    input wire logic read_restart_in,
    input wire logic [5:0] cycle_in,
    input wire logic shift_in,
    input wire logic store_word_in,
    input wire logic cycle_end_in,
    input wire logic instr_done_in,
    output logic maint_mode_out,
    output logic busy_out,
    output logic stop_clock_out,
    output logic read_restart_block_out,
    output logic cpu_read_restart_block_out,
    output logic dummy_cycle_out,
    output logic [17:0] mdl_data_out,
    output logic mdl_oe_out,
    output logic [17:0] instr_reg_out,
    output logic [17:0] operand_buffer_out,
    output logic [17:0] addr_reg_out,
    output logic [17:0] diag_instr_reg_out,
    output logic [17:0] diag_addr_reg_out,
    output logic dump_req_out,
    output logic [3:0] dump_index_out,
    output logic step_out,
    output logic [2:0] phase_out,
    output logic [2:0] tstate_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctl_state_t state_q, state_d;
    logic maint_q, maint_d;
    logic busy_q, busy_d;
    logic stop_q, stop_d;
    logic rrb_q, rrb_d;
    logic crrb_q, crrb_d;
    logic dummy_q, dummy_d;
    logic dummy_done_q, dummy_done_d;
    logic nop_q, nop_d;
    logic [17:0] ir_q, ir_d;
    logic [17:0] buf_q, buf_d;
    logic [17:0] ar_q, ar_d;
    logic [17:0] dir_q, dir_d;
    logic [17:0] dar_q, dar_d;
    logic [3:0] idx_q, idx_d;
    logic run;
    logic stepping;
    logic step;
    logic [2:0] phase;
    logic [2:0] tstate;

    // ------------------------------------------------------------
    // clock sequencing and step detection
    // ------------------------------------------------------------
    // the clock runs while not stopped and not at the halt point in the dummy state; stepping only in step state
    // the halt point itself freezes the phase, so the stop lands on ts3 ph3
    assign run = !stop_q && !(state_q == ST_DUMMY && at_fetch_halt(phase, tstate, cycle_in));
    assign stepping = (state_q == ST_STEP) && run;

    phase_gen u_phase (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .run_in(run),
        .phase_out(phase),
        .tstate_out(tstate)
    );

    step_detect u_step (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .enable_in(stepping),
        .phase_in(phase),
        .tstate_in(tstate),
        .cycle_in(cycle_in),
        .shift_in(shift_in),
        .store_word_in(store_word_in),
        .step_out(step)
    );

    // decoding of the halt point, used by the run gate and the dummy state
    function automatic logic at_fetch_halt(input logic [2:0] ph, input logic [2:0] ts,
                                           input logic [5:0] cyc);
        at_fetch_halt = ph[2] && ts[2] && cyc[0];
    endfunction : at_fetch_halt

    // ------------------------------------------------------------
    // control sequencer
    // ------------------------------------------------------------
    // next-state and register updates for the whole maintenance flow
    always_comb begin
        state_d = state_q;
        maint_d = maint_q;
        busy_d = busy_q;
        stop_d = stop_q;
        rrb_d = rrb_q;
        crrb_d = crrb_q;
        dummy_d = dummy_q;
        dummy_done_d = dummy_done_q;
        nop_d = 1'b0;
        ir_d = ir_q;
        buf_d = buf_q;
        ar_d = ar_q;
        dir_d = dir_q;
        dar_d = dar_q;
        idx_d = idx_q;
        unique case (state_q)
            ST_IDLE: begin
                // only the mode-on instruction arms; cpu work passes untouched
                if (diag_mode_on_in) begin
                    maint_d = 1'b1;
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // first fp instruction copied alongside the cpu
                if (fp_instr_in && mem_valid_in) begin
                    ir_d = mem_word_in;
                    state_d = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                // operand-address word into the operand buffer
                if (mem_valid_in) begin
                    buf_d = mem_word_in;
                    busy_d = 1'b1;
                    // dummy cycle and restart block so cpu ignores this word
                    dummy_d = 1'b1;
                    rrb_d = 1'b1;
                    dummy_done_d = 1'b0;
                    state_d = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                // cpu waits on the block until the read restart arrives
                if (read_restart_in && !dummy_done_q) begin
                    // stand in for memory with a nop word
                    nop_d = 1'b1;
                    dummy_done_d = 1'b1;
                    // operand address strobed into the address register
                    ar_d = buf_q;
                end
                // execution halts at fetch ts3 ph3
                if (!stop_q && at_fetch_halt(phase, tstate, cycle_in)) begin
                    stop_d = 1'b1;
                end
                // release the cpu once both conditions hold; busy kept
                if (dummy_done_q && stop_q) begin
                    rrb_d = 1'b0;
                    dummy_d = 1'b0;
                    state_d = ST_HALTED;
                end
            end
            ST_HALTED: begin
                // with busy set any fp instruction is a command
                if (fp_instr_in && mem_valid_in) begin
                    dir_d = mem_word_in;
                    state_d = ST_CMD_ADDR;
                end
            end
            ST_CMD_ADDR: begin
                if (mem_valid_in) begin
                    // following word is the argument address
                    dar_d = mem_word_in;
                    // hold the cpu at ts3 ph3
                    crrb_d = 1'b1;
                    state_d = ST_CMD_NOP;
                end
            end
            ST_CMD_NOP: begin
                // reference done, drop the block and hand the cpu a nop
                if (read_restart_in) begin
                    crrb_d = 1'b0;
                    nop_d = 1'b1;
                    idx_d = 4'h0;
                    // bit 11 picks step and read over plain read
                    if (dir_q[MODE_BIT]) begin
                        stop_d = 1'b0;
                        state_d = ST_STEP;
                    end else begin
                        state_d = ST_READ;
                    end
                end
            end
            ST_STEP: begin
                // each counted step takes one off the command register
                if (step) begin
                    dir_d = dir_q - 18'h00001;
                end
                // leave on the decrement that reaches the base, so no extra step slips in
                if (instr_done_in) begin
                    busy_d = 1'b0;
                    stop_d = 1'b1;
                    state_d = ST_READ;
                end else if (dir_d == STEP_BASE || cycle_end_in) begin
                    stop_d = 1'b1;
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                // a step launched on the way out still takes its decrement
                if (step) begin
                    dir_d = dir_q - 18'h00001;
                end
                // one memory cycle per word, address steps after each
                if (read_restart_in) begin
                    dar_d = dar_q + 18'h00001;
                    idx_d = idx_q + 4'h1;
                    if (idx_q == DUMP_LAST) begin
                        // partial instruction survives; finished one rearms entry
                        state_d = busy_q ? ST_HALTED : ST_ARMED;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // reset clears mode, busy and inhibits and lets the clock run
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            maint_q <= 1'b0;
            busy_q <= 1'b0;
            stop_q <= 1'b0;
            rrb_q <= 1'b0;
            crrb_q <= 1'b0;
            dummy_q <= 1'b0;
            dummy_done_q <= 1'b0;
            nop_q <= 1'b0;
            ir_q <= WORD_RESET;
            buf_q <= WORD_RESET;
            ar_q <= WORD_RESET;
            dir_q <= WORD_RESET;
            dar_q <= WORD_RESET;
            idx_q <= 4'h0;
        end else begin
            state_q <= state_d;
            maint_q <= maint_d;
            busy_q <= busy_d;
            stop_q <= stop_d;
            rrb_q <= rrb_d;
            crrb_q <= crrb_d;
            dummy_q <= dummy_d;
            dummy_done_q <= dummy_done_d;
            nop_q <= nop_d;
            ir_q <= ir_d;
            buf_q <= buf_d;
            ar_q <= ar_d;
            dir_q <= dir_d;
            dar_q <= dar_d;
            idx_q <= idx_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign maint_mode_out = maint_q;
    assign busy_out = busy_q;
    assign stop_clock_out = stop_q;
    assign read_restart_block_out = rrb_q;
    assign cpu_read_restart_block_out = crrb_q;
    assign dummy_cycle_out = dummy_q;
    // lines carry the nop only while enabled, zero otherwise
    assign mdl_oe_out = nop_q;
    assign mdl_data_out = nop_q ? NOP_WORD : WORD_RESET;
    assign instr_reg_out = ir_q;
    assign operand_buffer_out = buf_q;
    assign addr_reg_out = ar_q;
    assign diag_instr_reg_out = dir_q;
    assign diag_addr_reg_out = dar_q;
    assign dump_req_out = (state_q == ST_READ);
    assign dump_index_out = idx_q;
    assign step_out = step;
    assign phase_out = phase;
    assign tstate_out = tstate;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_mode_entry: assert property ($rose(maint_q) |-> $past(diag_mode_on_in))
        else $error("maintenance mode entered without mode-on");
    a_block_on_operand: assert property (state_q == ST_CAPTURE && mem_valid_in
        |=> rrb_q && dummy_q && buf_q == $past(mem_word_in))
        else $error("operand word not blocked");
    a_nop_value: assert property (mdl_oe_out |-> mdl_data_out == 18'h39000)
        else $error("wrong word on data lines");
    a_fetch_halt: assert property (state_q == ST_DUMMY && !stop_q
        && at_fetch_halt(phase, tstate, cycle_in) |=> stop_q && $stable(phase))
        else $error("no halt at fetch ts3 ph3");
    a_release_busy: assert property (state_q == ST_DUMMY && dummy_done_q && stop_q
        |=> !rrb_q && busy_q && maint_q && state_q == ST_HALTED)
        else $error("release wrong after dummy cycle");
    a_cmd_block: assert property (state_q == ST_CMD_ADDR && mem_valid_in
        |=> crrb_q ##0 dar_q == $past(mem_word_in))
        else $error("command not followed by block");
    a_nop_release: assert property (state_q == ST_CMD_NOP && read_restart_in
        |=> !crrb_q && mdl_oe_out ##1 !mdl_oe_out)
        else $error("nop not driven once on release");
    a_mode_select: assert property (state_q == ST_CMD_NOP && read_restart_in
        |=> state_q == ($past(dir_q[MODE_BIT]) ? ST_STEP : ST_READ))
        else $error("bit 11 mode chosen wrongly");
    a_dump_addr: assert property (state_q == ST_READ && read_restart_in
        |=> dar_q == $past(dar_q) + 18'h00001)
        else $error("dump address not stepped");
    a_step_dec: assert property (state_q == ST_STEP && step
        |=> dir_q == $past(dir_q) - 18'h00001)
        else $error("step did not decrement command");
    a_step_gate: assert property (step |-> $past(state_q == ST_STEP) && $past(run))
        else $error("step counted while not stepping");
    c_halted: cover property (state_q == ST_DUMMY ##1 state_q == ST_HALTED);
    c_step_done: cover property (state_q == ST_STEP ##1 state_q == ST_READ);
    c_dump_done: cover property (state_q == ST_READ && idx_q == DUMP_LAST && read_restart_in);
endmodule : fp_maintenance_step_control
`default_nettype wire

/* test/host_bus_model.sv */
// host cpu and shared memory bus model facing the maintenance step block
// assumes the bench calls its tasks from one process at a time
`default_nettype none
module host_bus_model
    import fpm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rrb_in,
    input wire logic cpu_rrb_in,
    input wire logic mdl_oe_in,
    input wire logic [17:0] mdl_data_in,
    output logic mem_valid_out,
    output logic fp_instr_out,
    output logic [17:0] mem_word_out,
    output logic read_restart_out,
    output logic [17:0] mem_input_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // quiet bus at time zero
    initial begin
        mem_valid_out = 1'b0;
        fp_instr_out = 1'b0;
        mem_word_out = 18'h00000;
        read_restart_out = 1'b0;
        mem_input_out = 18'h00000;
    end
    // one fetched word; a released bus shows the inverse, not the old value
    task automatic fetch(input logic [17:0] word, input logic is_fp);
        while (rrb_in === 1'b1 || cpu_rrb_in === 1'b1) @(posedge ref_clk_in);
        @(posedge ref_clk_in);
        mem_valid_out <= 1'b1;
        fp_instr_out <= is_fp;
        mem_word_out <= word;
        @(posedge ref_clk_in);
        mem_valid_out <= 1'b0;
        fp_instr_out <= 1'b0;
        mem_word_out <= ~word;
    endtask : fetch
    // one memory read restart pulse
    task automatic restart();
        @(posedge ref_clk_in);
        read_restart_out <= 1'b1;
        @(posedge ref_clk_in);
        read_restart_out <= 1'b0;
    endtask : restart
    always @(posedge ref_clk_in) begin
        if (mdl_oe_in === 1'b1) begin
            mem_input_out <= mdl_data_in;
        end
    end
endmodule : host_bus_model
`default_nettype wire

/* test/fp_maintenance_step_control_tb.sv */
// self-checking bench for the maintenance step-control block
// assumes the host model drives all bus handshakes off the rising edge
`default_nettype none
module fp_maintenance_step_control_tb
    import fpm_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic diag_mode_on_in = 1'b0;
    logic [5:0] cycle_in = 6'h01;
    logic shift_in = 1'b0;
    logic store_word_in = 1'b0;
    logic cycle_end_in = 1'b0;
    logic mem_valid, fp_instr, read_restart, maint_mode, busy, stop_clock, rrb, cpu_rrb;
    logic dummy, mdl_oe, dump_req, step, prev_ph3;
    logic [17:0] mem_word, mem_input, mdl_data, instr_reg, op_buf, addr_reg, dir, diag_addr_reg;
    logic [17:0] w_instr, w_op, w_addr, w_cmd;
    logic [3:0] dump_index;
    logic [2:0] phase, tstate;
    logic [17:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int n_steps = 0;
    int n_req;
    always #20 ref_clk_in = ~ref_clk_in;
    fp_maintenance_step_control DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .diag_mode_on_in(diag_mode_on_in), .fp_instr_in(fp_instr), .mem_valid_in(mem_valid),
        .mem_word_in(mem_word), .read_restart_in(read_restart), .cycle_in(cycle_in),
        .shift_in(shift_in), .store_word_in(store_word_in), .cycle_end_in(cycle_end_in),
        .instr_done_in(1'b0), .maint_mode_out(maint_mode), .busy_out(busy),
        .stop_clock_out(stop_clock), .read_restart_block_out(rrb),
        .cpu_read_restart_block_out(cpu_rrb), .dummy_cycle_out(dummy),
        .mdl_data_out(mdl_data), .mdl_oe_out(mdl_oe), .instr_reg_out(instr_reg),
        .operand_buffer_out(op_buf), .addr_reg_out(addr_reg), .diag_instr_reg_out(dir),
        .diag_addr_reg_out(diag_addr_reg), .dump_req_out(dump_req), .dump_index_out(dump_index),
        .step_out(step), .phase_out(phase), .tstate_out(tstate));
    host_bus_model cpu (.ref_clk_in(ref_clk_in), .rrb_in(rrb), .cpu_rrb_in(cpu_rrb),
        .mdl_oe_in(mdl_oe), .mdl_data_in(mdl_data), .mem_valid_out(mem_valid),
        .fp_instr_out(fp_instr), .mem_word_out(mem_word), .read_restart_out(read_restart),
        .mem_input_out(mem_input));
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    function automatic logic flag(input int sel);
        case (sel)
            0: return stop_clock;
            1: return ~rrb;
            2: return dump_req;
            default: return ~dump_req;
        endcase
    endfunction : flag
    // bounded wait on a level, then insist on it
    task automatic wait_until(input int sel);
        int k;
        for (k = 0; k < 200 && flag(sel) !== 1'b1; k++) @(negedge ref_clk_in);
        check({17'h0, flag(sel)}, 18'h00001);
    endtask : wait_until
    task automatic command(input logic [17:0] cmd, input logic [17:0] adr);
        cpu.fetch(cmd, 1'b1);
        cpu.fetch(adr, 1'b0);
        repeat (2) @(negedge ref_clk_in);
        check(dir, cmd);
        check(diag_addr_reg, adr);
        check({17'h0, cpu_rrb}, 18'h00001);
        exp_q.push_back(NOP_WORD);
        n_steps = 0;
        cpu.restart();
        repeat (3) @(negedge ref_clk_in);
        check({17'h0, cpu_rrb}, 18'h00000);
        check(mem_input, NOP_WORD);
    endtask : command
    // sixteen words, one restart each; the address walks up by one per word
    task automatic dump(input logic [17:0] adr);
        int i;
        wait_until(2);
        for (i = 0; i < 16; i++) begin
            @(negedge ref_clk_in);
            check({14'h0, dump_index}, 18'(i));
            check(diag_addr_reg, adr + 18'(i));
            cpu.restart();
        end
        wait_until(3);
        check(diag_addr_reg, adr + 18'h00010);
        check({16'h0, busy, maint_mode}, 18'h00003);
    endtask : dump
    // nop answers are matched in order; a step must follow a running phase three
    always @(negedge ref_clk_in) begin
        if (mdl_oe === 1'b1) begin
            check(mdl_data, (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3ffff);
        end
        if (step === 1'b1) begin
            n_steps++;
            check({17'h0, prev_ph3}, 18'h00001);
        end
        prev_ph3 = phase[2] & ~stop_clock;
    end
    // random strobes; shift only counts in the align and adjust cycles
    always @(posedge ref_clk_in) begin
        shift_in <= 1'($urandom());
        store_word_in <= 1'($urandom());
    end
    initial begin
        void'($urandom(32'hf3bc));
        @(negedge ref_clk_in);
        check({9'h0, phase, tstate, busy, maint_mode, rrb}, 18'h00048);
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        w_instr = 18'($urandom());
        w_op = 18'($urandom());
        cpu.fetch(w_instr, 1'b1);
        repeat (2) @(negedge ref_clk_in);
        check({15'h0, maint_mode, busy, dummy}, 18'h00000);
        @(posedge ref_clk_in);
        diag_mode_on_in <= 1'b1;
        @(posedge ref_clk_in);
        diag_mode_on_in <= 1'b0;
        @(negedge ref_clk_in);
        check({17'h0, maint_mode}, 18'h00001);
        cpu.fetch(w_op, 1'b0);
        cpu.fetch(w_instr, 1'b1);
        cpu.fetch(w_op, 1'b0);
        repeat (2) @(negedge ref_clk_in);
        check(instr_reg, w_instr);
        check(op_buf, w_op);
        check({15'h0, busy, dummy, rrb}, 18'h00007);
        exp_q.push_back(NOP_WORD);
        cpu.restart();
        wait_until(0);
        wait_until(1);
        check({15'h0, busy, maint_mode, dummy}, 18'h00006);
        check(addr_reg, w_op);
        check({12'h0, phase, tstate}, 18'h00024);
        // step command is base plus count
        n_req = 1 + $urandom_range(3);
        w_addr = 18'($urandom());
        @(posedge ref_clk_in);
        cycle_in <= 6'h04;
        command(STEP_BASE + 18'(n_req), w_addr);
        dump(w_addr);
        check(18'(n_steps), 18'(n_req));
        check(dir, STEP_BASE + 18'(n_req) - 18'(n_steps));
        // mode bit counts from the most significant end, so it sits at bit 6 here
        w_cmd = 18'($urandom()) & ~18'h00040;
        w_addr = 18'($urandom());
        command(w_cmd, w_addr);
        dump(w_addr);
        check(dir, w_cmd);
        check(18'(n_steps), 18'h00000);
        // a long request cut short by the end of the cycle
        n_req = 40;
        command(STEP_BASE + 18'(n_req), w_addr);
        repeat (6) @(posedge ref_clk_in);
        cycle_end_in <= 1'b1;
        @(posedge ref_clk_in);
        cycle_end_in <= 1'b0;
        dump(w_addr);
        check({17'h0, 1'(n_steps > 0 && n_steps < n_req)}, 18'h00001);
        check(dir, STEP_BASE + 18'(n_req) - 18'(n_steps));
        check(18'(exp_q.size()), 18'h00000);
        final_report();
    end
    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (3000) @(posedge ref_clk_in);
        miscompares++;
        final_report();
    end
endmodule : fp_maintenance_step_control_tb
`default_nettype wire
